// >>> pkg/rotate_right_defines.vh
// Constants for the rotate-right datapath unit
`ifndef ROTATE_RIGHT_DEFINES_VH
`define ROTATE_RIGHT_DEFINES_VH
`define ROT_WIDTH           8
`define ROT_MSB             7
`define ROT_LSB             0
`define ROT_OP_WIDTH        2
`define ROT_OP_MEM          2'h0
`define ROT_OP_TO_ACCUM     2'h1
`define ROT_OP_MEM_C        2'h2
`define ROT_OP_TO_ACCUM_C   2'h3
`define ROT_ACCUM_RESET     8'h00
`define ROT_WDATA_RESET     8'h00
`define ROT_CARRY_RESET     1'h0
`endif

// >>> design/rotate_right_core.v
// Combinational rotate-right of one byte, optionally through carry
`include "rotate_right_defines.vh"
module rotate_right_core (
	input  wire [`ROT_WIDTH-1:0] i_operand,
	input  wire                  i_carry_in,
	input  wire                  i_thru_carry,
	output wire [`ROT_WIDTH-1:0] o_result,
	output wire                  o_carry_out
);
	// Top bit is either old bit 0 or old carry
	assign o_result    = {(i_thru_carry ? i_carry_in : i_operand[`ROT_LSB]),
		i_operand[`ROT_MSB:`ROT_LSB+1]};
	assign o_carry_out = i_operand[`ROT_LSB];
endmodule

// >>> design/rotate_right_unit.v
// Rotate-right unit: four byte rotates with memory or accumulator result
//
// Behaviour
// - Memory rotate right: bits shift down, old bit 0 into bit 7, written back.
// - Rotate to accumulator: same rotation loaded into accumulator, memory untouched.
// - Memory rotate through carry: nine-bit ring, old bit 0 into carry.
// - Through-carry memory result takes old carry in bit 7, written back.
// - Through-carry to accumulator: result into accumulator and carry, memory kept.
// - Through-carry to accumulator: carry takes bit 0 of the memory operand.
`include "rotate_right_defines.vh"

module rotate_right_unit (
	input  wire                     i_clock,
	input  wire                     i_rstn,
	input  wire                     i_start,
	input  wire [`ROT_OP_WIDTH-1:0] i_op,
	input  wire [`ROT_WIDTH-1:0]    i_mem_data,
	output reg                      o_mem_we,
	output reg  [`ROT_WIDTH-1:0]    o_mem_wdata,
	output wire [`ROT_WIDTH-1:0]    o_accumulator,
	output wire                     o_carry,
	output reg                      o_done
);

	// Two states: idle, or showing done for the cycle after a start
	localparam ST_IDLE = 1'h0;
	localparam ST_DONE = 1'h1;

	reg  [`ROT_WIDTH-1:0] accumulator_reg;
	reg  [`ROT_WIDTH-1:0] accumulator_next;
	reg                   carry_reg;
	reg                   carry_next;
	reg                   state_reg;
	reg                   state_next;
	reg                   mem_we_next;
	reg  [`ROT_WIDTH-1:0] mem_wdata_next;
	reg                   done_next;
	wire [`ROT_WIDTH-1:0] rot_result;
	wire                  rot_carry;
	wire                  op_taken;
	wire                  op_thru_carry;

	// Through-carry forms feed the old carry into the top bit
	function is_thru_carry;
		input [`ROT_OP_WIDTH-1:0] op;
		is_thru_carry = (op == `ROT_OP_MEM_C) || (op == `ROT_OP_TO_ACCUM_C);
	endfunction

	assign op_taken      = i_start;
	assign op_thru_carry = is_thru_carry(i_op);

	// One rotator is shared by all four operations
	rotate_right_core u_core (
		.i_operand    (i_mem_data),
		.i_carry_in   (carry_reg),
		.i_thru_carry (op_thru_carry),
		.o_result     (rot_result),
		.o_carry_out  (rot_carry)
	);

	assign o_accumulator = accumulator_reg;
	assign o_carry       = carry_reg;

	// A start while done is shown is taken as a new operation
	always @* begin
		state_next = ST_IDLE;
		case (state_reg)
			ST_IDLE: begin
				if (op_taken) begin
					state_next = ST_DONE;
				end
			end
			ST_DONE: begin
				if (op_taken) begin
					state_next = ST_DONE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always @* begin
		done_next = 1'h0;
		case (state_next)
			ST_IDLE: begin
				done_next = 1'h0;
			end
			ST_DONE: begin
				done_next = 1'h1;
			end
			default: begin
				done_next = 1'h0;
			end
		endcase
	end

	// Only the accumulator forms load it
	always @* begin
		accumulator_next = accumulator_reg;
		if (op_taken) begin
			case (i_op)
				`ROT_OP_MEM: begin
					accumulator_next = accumulator_reg;
				end
				`ROT_OP_TO_ACCUM: begin
					accumulator_next = rot_result;
				end
				`ROT_OP_MEM_C: begin
					accumulator_next = accumulator_reg;
				end
				`ROT_OP_TO_ACCUM_C: begin
					accumulator_next = rot_result;
				end
				default: begin
					accumulator_next = accumulator_reg;
				end
			endcase
		end
	end

	// Plain rotates never touch the carry; no other flag lives here
	always @* begin
		carry_next = carry_reg;
		if (op_taken) begin
			case (i_op)
				`ROT_OP_MEM: begin
					carry_next = carry_reg;
				end
				`ROT_OP_TO_ACCUM: begin
					carry_next = carry_reg;
				end
				`ROT_OP_MEM_C: begin
					carry_next = rot_carry;
				end
				`ROT_OP_TO_ACCUM_C: begin
					carry_next = rot_carry;
				end
				default: begin
					carry_next = carry_reg;
				end
			endcase
		end
	end

	// No write strobe for accumulator forms keeps the memory byte intact
	always @* begin
		mem_we_next    = 1'h0;
		mem_wdata_next = o_mem_wdata;
		if (op_taken) begin
			case (i_op)
				`ROT_OP_MEM: begin
					mem_we_next    = 1'h1;
					mem_wdata_next = rot_result;
				end
				`ROT_OP_TO_ACCUM: begin
					mem_we_next = 1'h0;
				end
				`ROT_OP_MEM_C: begin
					mem_we_next    = 1'h1;
					mem_wdata_next = rot_result;
				end
				`ROT_OP_TO_ACCUM_C: begin
					mem_we_next = 1'h0;
				end
				default: begin
					mem_we_next = 1'h0;
				end
			endcase
		end
	end

	// Synchronous reset; each register has its own process
	always @(posedge i_clock) begin
		if (!i_rstn) begin
			state_reg <= ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always @(posedge i_clock) begin
		if (!i_rstn) begin
			accumulator_reg <= `ROT_ACCUM_RESET;
		end else begin
			accumulator_reg <= accumulator_next;
		end
	end

	always @(posedge i_clock) begin
		if (!i_rstn) begin
			carry_reg <= `ROT_CARRY_RESET;
		end else begin
			carry_reg <= carry_next;
		end
	end

	always @(posedge i_clock) begin
		if (!i_rstn) begin
			o_mem_we <= 1'h0;
		end else begin
			o_mem_we <= mem_we_next;
		end
	end

	always @(posedge i_clock) begin
		if (!i_rstn) begin
			o_mem_wdata <= `ROT_WDATA_RESET;
		end else begin
			o_mem_wdata <= mem_wdata_next;
		end
	end

	always @(posedge i_clock) begin
		if (!i_rstn) begin
			o_done <= 1'h0;
		end else begin
			o_done <= done_next;
		end
	end
endmodule

// >>> verif/rotate_right_checker_assertions.sv
// Port checker for the rotate-right unit
module rotate_right_checker (
	input logic       i_clock,
	input logic       i_rstn,
	input logic       i_start,
	input logic       o_mem_we,
	input logic       o_carry,
	input logic       o_done,
	input logic [1:0] i_op,
	input logic [7:0] i_mem_data,
	input logic [7:0] o_mem_wdata,
	input logic [7:0] o_accumulator
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	wire [6:0] h = i_mem_data[7:1];
	wire       b = i_mem_data[0];
	property p_r1; i_start && i_op == 0 |=> o_mem_we && o_mem_wdata == {$past(b), $past(h)}; endproperty
	a_r1: assert property (p_r1) else $error("memory rotate wrong");
	property p_r2; i_start && i_op == 1 |=> !o_mem_we && o_accumulator == {$past(b), $past(h)}; endproperty
	a_r2: assert property (p_r2) else $error("accumulator rotate wrong");
	property p_r3; i_start && i_op[1] |=> o_carry == $past(b); endproperty
	a_r3: assert property (p_r3) else $error("carry out wrong");
	property p_r4; i_start && i_op == 2 |=> o_mem_we && o_mem_wdata == {$past(o_carry), $past(h)}; endproperty
	a_r4: assert property (p_r4) else $error("memory carry rotate wrong");
	property p_r5; i_start && i_op == 3 |=> !o_mem_we && o_accumulator == {$past(o_carry), $past(h)}; endproperty
	a_r5: assert property (p_r5) else $error("accumulator carry rotate wrong");
	property p_r7; !(i_start && i_op[1]) |=> $stable(o_carry); endproperty
	a_r7: assert property (p_r7) else $error("carry changed");
	// Idle cycles must not write memory back
	property p_we; !i_start |=> !o_mem_we && !o_done; endproperty
	a_we: assert property (p_we) else $error("stray write");
	c_chain: cover property (i_start && i_op == 2 ##1 i_start && i_op == 3);
	c_acc: cover property (i_start && i_op == 1);
	c_carry: cover property (o_carry && o_done);
endmodule
bind rotate_right_unit rotate_right_checker rotate_right_checker_inst (.*);

// >>> verif/tb_top.sv
// Self-checking bench for the rotate-right unit
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       c = 0, r = 0, s = 0, we, cy, dn;
	logic [1:0] op = 0;
	logic [7:0] d = 0, wd, ac;
	int         failures = 0, n_compared = 0;
	initial forever #2 c = ~c;
	rotate_right_unit rotate_right_unit_inst (.i_clock(c), .i_rstn(r), .i_start(s), .i_op(op),
		.i_mem_data(d), .o_mem_we(we), .o_mem_wdata(wd), .o_accumulator(ac), .o_carry(cy),
		.o_done(dn));
	task automatic chk(logic [18:0] e);
		n_compared++;
		if ({we, dn, cy, wd, ac} !== e) begin
			failures++;
			$display("mismatch outputs exp %h got %h", e, {we, dn, cy, wd, ac});
		end
	endtask
	// One op per call; result is judged 1 ns after the edge that takes it
	task automatic run(logic [1:0] o, logic [7:0] x, logic [18:0] e);
		@(posedge c) begin s <= 1; op <= o; d <= x; end
		@(posedge c) s <= 0;
		#1 chk(e);
	endtask
	task automatic t_rot;
		run(2'h0, 8'h01, {3'h6, 8'h80, 8'h00});
		run(2'h1, 8'hfe, {3'h2, 8'h80, 8'h7f});
	endtask
	task automatic t_carry;
		run(2'h2, 8'h01, {3'h7, 8'h00, 8'h7f});
		run(2'h3, 8'h02, {3'h2, 8'h00, 8'h81});
		run(2'h3, 8'h03, {3'h3, 8'h00, 8'h01});
		run(2'h0, 8'h02, {3'h7, 8'h01, 8'h01});
		run(2'h2, 8'hfe, {3'h6, 8'hff, 8'h01});
	endtask
	task automatic t_rst;
		@(posedge c) r <= 0;
		@(posedge c) r <= 1;
		#1 chk(19'h0);
		run(2'h2, 8'h01, {3'h7, 8'h00, 8'h00});
	endtask
	task automatic results;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge c);
		r <= 1;
		t_rot;
		t_carry;
		t_rst;
		results;
	end
	initial begin
		#2000;
		failures++;
		results;
	end
endmodule
